/* ibf_top.sv */
// Interleaved buffer memory: twelve access channels over eight core modules.
// Assumes requesters hold a request until its ack and the supervisor loads start addresses.
`timescale 1ns/1ns
module ibf_top #(
   parameter int CYCLE_CLKS = ibf_pkg::CYCLE_CLKS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [ibf_pkg::NUM_CH-1:0] ch_load,
   input wire logic [ibf_pkg::ADDR_W-1:0] ch_load_addr [ibf_pkg::NUM_CH],
   input wire logic [ibf_pkg::NUM_CH-1:0] ch_req_valid,
   input wire logic [ibf_pkg::NUM_CH-1:0] ch_req_write,
   input wire logic [ibf_pkg::DATA_W-1:0] ch_req_wdata [ibf_pkg::NUM_CH],
   output logic [ibf_pkg::NUM_CH-1:0] ch_req_ack,
   output logic [ibf_pkg::NUM_CH-1:0] ch_page_end,
   output logic [ibf_pkg::ADDR_W-1:0] ch_addr [ibf_pkg::NUM_CH],
   output logic [ibf_pkg::NUM_CH-1:0] ch_rvalid,
   output logic [ibf_pkg::DATA_W-1:0] ch_rdata [ibf_pkg::NUM_CH],
   output logic [ibf_pkg::NUM_CH-1:0] ch_rperr,
   input wire logic [ibf_pkg::NUM_CH-1:0] ch_rready,
   output logic parity_alarm
);
   localparam int NC = ibf_pkg::NUM_CH;
   localparam int NB = ibf_pkg::NUM_BANK;
   localparam int DW = ibf_pkg::DATA_W;
   localparam int AW = ibf_pkg::ADDR_W;

   // ---------------------------------------------------------------
   // Module side signals
   // ---------------------------------------------------------------
   ibf_bank_if bus [NB] ();
   logic [NB-1:0] bk_start;
   logic [NB-1:0] bk_write;
   logic [ibf_pkg::INDEX_W-1:0] bk_index [NB];
   logic [DW-1:0] bk_wdata [NB];
   logic [ibf_pkg::CH_W-1:0] bk_chan [NB];
   logic [NB-1:0] bk_done_ready;
   logic [NB-1:0] bk_free;
   logic [NB-1:0] bk_done_valid;
   logic [DW-1:0] bk_rdata [NB];
   logic [NB-1:0] bk_perr;

   // ---------------------------------------------------------------
   // Channel state
   // ---------------------------------------------------------------
   logic [AW-1:0] addr [NC];
   logic [AW-1:0] next_addr [NC];
   logic [NC-1:0] ack, next_ack;
   logic [NC-1:0] page_end, next_page_end;
   // Per-channel order of modules holding outstanding reads
   logic [ibf_pkg::BANK_SEL_W-1:0] ord [NC][ibf_pkg::ORD_DEPTH];
   logic [ibf_pkg::BANK_SEL_W-1:0] next_ord [NC][ibf_pkg::ORD_DEPTH];
   logic [ibf_pkg::ORD_PTR_W-1:0] ord_wr [NC];
   logic [ibf_pkg::ORD_PTR_W-1:0] next_ord_wr [NC];
   logic [ibf_pkg::ORD_PTR_W-1:0] ord_rd [NC];
   logic [ibf_pkg::ORD_PTR_W-1:0] next_ord_rd [NC];
   logic [ibf_pkg::ORD_CNT_W-1:0] ord_cnt [NC];
   logic [ibf_pkg::ORD_CNT_W-1:0] next_ord_cnt [NC];
   // Two-entry return buffer: output stage plus skid stage
   logic [NC-1:0] out_valid, next_out_valid;
   logic [DW-1:0] out_data [NC];
   logic [DW-1:0] next_out_data [NC];
   logic [NC-1:0] out_perr, next_out_perr;
   logic [NC-1:0] skid_valid, next_skid_valid;
   logic [DW-1:0] skid_data [NC];
   logic [DW-1:0] next_skid_data [NC];
   logic [NC-1:0] skid_perr, next_skid_perr;
   logic alarm, next_alarm;
   logic [NC-1:0] taken;

   // ---------------------------------------------------------------
   // Core modules
   // ---------------------------------------------------------------
   // Each module owns one residue of the low address bits, a fixed visiting order
   for (genvar b = 0; b < NB; b++) begin : g_bank
      assign bus[b].start = bk_start[b];
      assign bus[b].write = bk_write[b];
      assign bus[b].index = bk_index[b];
      assign bus[b].wdata = bk_wdata[b];
      assign bus[b].chan = bk_chan[b];
      assign bus[b].done_ready = bk_done_ready[b];
      assign bk_free[b] = bus[b].free;
      assign bk_done_valid[b] = bus[b].done_valid;
      assign bk_rdata[b] = bus[b].rdata;
      assign bk_perr[b] = bus[b].perr;

      ibf_bank #(
         .WORDS(ibf_pkg::BANK_WORDS),
         .CYCLE_CLKS(CYCLE_CLKS)
      ) u_bank (
         .clk(clk),
         .reset_n(reset_n),
         .port(bus[b])
      );
   end

   // ---------------------------------------------------------------
   // Arbitration and address stepping
   // ---------------------------------------------------------------
   // A stale request during its ack cycle is ignored, so a channel issues at most every
   // second clock (80 ns), inside the sequential spacing
   always_comb begin
      logic found;
      found = 1'b0;
      taken = '0;
      bk_start = '0;
      bk_write = '0;
      for (int b = 0; b < NB; b++) begin
         bk_index[b] = '0;
         bk_wdata[b] = '0;
         bk_chan[b] = '0;
      end
      for (int b = 0; b < NB; b++) begin
         found = 1'b0;
         // Lowest channel number wins; losers simply stay pending
         for (int c = 0; c < NC; c++) begin
            if (!found && bk_free[b] && ch_req_valid[c] && !ack[c] && !ch_load[c] &&
                addr[c][ibf_pkg::BANK_SEL_W-1:0] == ibf_pkg::BANK_SEL_W'(b) &&
                ord_cnt[c] < ibf_pkg::ORD_CNT_W'(ibf_pkg::ORD_DEPTH)) begin
               found = 1'b1;
               taken[c] = 1'b1;
               bk_start[b] = 1'b1;
               bk_chan[b] = ibf_pkg::CH_W'(c);
               bk_write[b] = ch_req_write[c];
               bk_index[b] = addr[c][AW-1:ibf_pkg::BANK_SEL_W];
               bk_wdata[b] = ch_req_wdata[c];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Channel sequencing, return ordering and buffering
   // ---------------------------------------------------------------
   // Reads come back in issue order per channel; the skid stage lets a stalled
   // receiver hold data back without losing a word
   always_comb begin
      logic [ibf_pkg::BANK_SEL_W-1:0] head;
      logic push;
      logic pop_ord;
      logic push_ord;
      head = '0;
      push = 1'b0;
      pop_ord = 1'b0;
      push_ord = 1'b0;
      next_addr = addr;
      next_ack = '0;
      next_page_end = '0;
      next_ord = ord;
      next_ord_wr = ord_wr;
      next_ord_rd = ord_rd;
      next_ord_cnt = ord_cnt;
      next_out_valid = out_valid;
      next_out_data = out_data;
      next_out_perr = out_perr;
      next_skid_valid = skid_valid;
      next_skid_data = skid_data;
      next_skid_perr = skid_perr;
      next_alarm = 1'b0;
      bk_done_ready = '0;
      for (int c = 0; c < NC; c++) begin
         push_ord = 1'b0;
         pop_ord = 1'b0;
         // Address load from the supervisor takes precedence over stepping
         if (ch_load[c]) begin
            next_addr[c] = ch_load_addr[c];
         end else if (taken[c]) begin
            next_addr[c] = addr[c] + AW'(1);
            next_ack[c] = 1'b1;
            next_page_end[c] = &addr[c][ibf_pkg::PAGE_OFS_W-1:0];
            if (!ch_req_write[c]) begin
               push_ord = 1'b1;
               next_ord[c][ord_wr[c]] = addr[c][ibf_pkg::BANK_SEL_W-1:0];
               next_ord_wr[c] = ord_wr[c] + ibf_pkg::ORD_PTR_W'(1);
            end
         end
         // Drain the output stage first, then refill from the skid stage
         if (out_valid[c] && ch_rready[c]) begin
            next_out_valid[c] = skid_valid[c];
            next_out_data[c] = skid_data[c];
            next_out_perr[c] = skid_perr[c];
            next_skid_valid[c] = 1'b0;
         end
         head = ord[c][ord_rd[c]];
         push = (ord_cnt[c] != '0) && !skid_valid[c] && bk_done_valid[head];
         if (push) begin
            bk_done_ready[head] = 1'b1;
            pop_ord = 1'b1;
            next_ord_rd[c] = ord_rd[c] + ibf_pkg::ORD_PTR_W'(1);
            next_alarm = next_alarm | bk_perr[head];
            if (!next_out_valid[c]) begin
               next_out_valid[c] = 1'b1;
               next_out_data[c] = bk_rdata[head];
               next_out_perr[c] = bk_perr[head];
            end else begin
               next_skid_valid[c] = 1'b1;
               next_skid_data[c] = bk_rdata[head];
               next_skid_perr[c] = bk_perr[head];
            end
         end
         if (push_ord && !pop_ord) begin
            next_ord_cnt[c] = ord_cnt[c] + ibf_pkg::ORD_CNT_W'(1);
         end else if (pop_ord && !push_ord) begin
            next_ord_cnt[c] = ord_cnt[c] - ibf_pkg::ORD_CNT_W'(1);
         end
      end
   end

   // Channel and buffer state registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         addr <= '{default: '0};
         ack <= '0;
         page_end <= '0;
         ord <= '{default: '{default: '0}};
         ord_wr <= '{default: '0};
         ord_rd <= '{default: '0};
         ord_cnt <= '{default: '0};
         out_valid <= '0;
         out_data <= '{default: '0};
         out_perr <= '0;
         skid_valid <= '0;
         skid_data <= '{default: '0};
         skid_perr <= '0;
         alarm <= 1'b0;
      end else begin
         addr <= next_addr;
         ack <= next_ack;
         page_end <= next_page_end;
         ord <= next_ord;
         ord_wr <= next_ord_wr;
         ord_rd <= next_ord_rd;
         ord_cnt <= next_ord_cnt;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
         out_perr <= next_out_perr;
         skid_valid <= next_skid_valid;
         skid_data <= next_skid_data;
         skid_perr <= next_skid_perr;
         alarm <= next_alarm;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ---------------------------------------------------------------
   assign ch_req_ack = ack;
   assign ch_page_end = page_end;
   assign ch_addr = addr;
   assign ch_rvalid = out_valid;
   assign ch_rdata = out_data;
   assign ch_rperr = out_perr;
   assign parity_alarm = alarm;

endmodule // ibf_top

/* ibf_pkg.sv */
// Shared constants, types and helpers for the interleaved buffer memory.
// Assumes one 25 MHz system clock and a synchronous active-low reset.
package ibf_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int NUM_CH = 12;            // Memory access channels
   localparam int CH_W = 4;               // Channel number width
   localparam int NUM_BANK = 8;           // Core modules
   localparam int BANK_SEL_W = 3;         // Low address bits that pick a module
   localparam int BANK_WORDS = 4096;      // Words per module
   localparam int INDEX_W = 12;           // Word index inside a module
   localparam int ADDR_W = 15;            // 32,768 words in all
   localparam int PAGE_OFS_W = 11;        // 2048 words per page
   localparam int DATA_W = 16;            // Data bits per word
   localparam int WORD_W = 18;            // Data plus two parity bits
   localparam int PAR_LSB = 16;           // Parity field position in a stored word
   localparam int ORD_DEPTH = 8;          // Reads a channel may keep in flight
   localparam int ORD_PTR_W = 3;
   localparam int ORD_CNT_W = 4;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int CYCLE_TIME_NS = 1100;   // Full cycle of one module
   // Least time, so rounded up to whole clocks
   localparam int CYCLE_CLKS = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEQ_TIME_NS = 136;      // Longest spacing of sequential words
   // Longest time, so rounded down, never below one clock
   localparam int SEQ_CLKS = (SEQ_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : SEQ_TIME_NS / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      BANK_IDLE = 3'h1,
      BANK_CYCLE = 3'h2,
      BANK_HOLD = 3'h4
   } ibf_bank_state_type;

   // One parity bit per data byte, high byte in the upper bit
   function automatic logic [1:0] ibf_parity(input logic [DATA_W-1:0] d);
      return {^d[15:8], ^d[7:0]};
   endfunction

endpackage

/* ibf_bank_if.sv */
// Connection between the channel arbiter and one core module.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ibf_bank_if;
   logic start;
   logic write;
   logic [ibf_pkg::INDEX_W-1:0] index;
   logic [ibf_pkg::DATA_W-1:0] wdata;
   logic [ibf_pkg::CH_W-1:0] chan;
   logic free;
   logic done_valid;
   logic done_ready;
   logic [ibf_pkg::DATA_W-1:0] rdata;
   logic perr;
   logic [ibf_pkg::CH_W-1:0] done_chan;

   modport ctrl (
      output start, write, index, wdata, chan, done_ready,
      input free, done_valid, rdata, perr, done_chan
   );
   modport bank (
      input start, write, index, wdata, chan, done_ready,
      output free, done_valid, rdata, perr, done_chan
   );
endinterface // ibf_bank_if

/* ibf_bank.sv */
// One core module: storage, cycle timer and a held read result.
// Assumes the arbiter starts it only while free and takes results by done_ready.
`timescale 1ns/1ns
module ibf_bank #(
   parameter int WORDS = ibf_pkg::BANK_WORDS,
   parameter int CYCLE_CLKS = ibf_pkg::CYCLE_CLKS
) (
   input wire logic clk,
   input wire logic reset_n,
   ibf_bank_if.bank port
);
   localparam int CNT_W = $clog2(CYCLE_CLKS + 1);
   // Loaded two short, so a written module is free again exactly CYCLE_CLKS clocks after its start
   localparam int LOAD_CNT = (CYCLE_CLKS > 1) ? CYCLE_CLKS - 2 : 0;

   ibf_pkg::ibf_bank_state_type state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [ibf_pkg::WORD_W-1:0] word, next_word;
   logic [ibf_pkg::CH_W-1:0] chan, next_chan;
   logic wr, next_wr;
   logic [ibf_pkg::WORD_W-1:0] mem [WORDS];
   logic [ibf_pkg::WORD_W-1:0] next_mem [WORDS];

   // ---------------------------------------------------------------
   // Cycle sequencing
   // ---------------------------------------------------------------
   // A module stays busy for the whole core cycle, so back-to-back hits on one module pace at it
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_word = word;
      next_chan = chan;
      next_wr = wr;
      next_mem = mem;
      case (state)
         ibf_pkg::BANK_IDLE: begin
            if (port.start) begin
               next_chan = port.chan;
               next_wr = port.write;
               next_cnt = CNT_W'(LOAD_CNT);
               next_state = ibf_pkg::BANK_CYCLE;
               if (port.write) begin
                  next_mem[port.index] = {ibf_pkg::ibf_parity(port.wdata), port.wdata};
               end else begin
                  next_word = mem[port.index];
               end
            end
         end
         ibf_pkg::BANK_CYCLE: begin
            if (cnt == '0) begin
               next_state = wr ? ibf_pkg::BANK_IDLE : ibf_pkg::BANK_HOLD;
            end else begin
               next_cnt = cnt - CNT_W'(1);
            end
         end
         ibf_pkg::BANK_HOLD: begin
            // Result waits here while the receiver stalls; nothing is dropped
            if (port.done_ready) begin
               next_state = ibf_pkg::BANK_IDLE;
            end
         end
         default: begin
            next_state = ibf_pkg::BANK_IDLE;
         end
      endcase
   end

   // Control state registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= ibf_pkg::BANK_IDLE;
         cnt <= '0;
         word <= '0;
         chan <= '0;
         wr <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         word <= next_word;
         chan <= next_chan;
         wr <= next_wr;
      end
   end

   // Storage carries no reset, as a core array would not
   always_ff @(posedge clk) begin
      mem <= next_mem;
   end

   // Status toward the arbiter
   assign port.free = (state == ibf_pkg::BANK_IDLE);
   assign port.done_valid = (state == ibf_pkg::BANK_HOLD);
   assign port.rdata = word[ibf_pkg::DATA_W-1:0];
   assign port.perr = (ibf_pkg::ibf_parity(word[ibf_pkg::DATA_W-1:0]) != word[ibf_pkg::WORD_W-1:ibf_pkg::PAR_LSB]);
   assign port.done_chan = chan;

endmodule // ibf_bank

/* ibf_top_asserts.sv */
// Concurrent checks on the ports of the interleaved buffer memory top.
// Assumes one clock and a synchronous active-low reset; bound to every ibf_top.
`timescale 1ns/1ns
module ibf_top_asserts #(
   parameter int CYCLE_CLKS = ibf_pkg::CYCLE_CLKS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [11:0] ch_load,
   input wire logic [14:0] ch_load_addr [12],
   input wire logic [11:0] ch_req_valid,
   input wire logic [11:0] ch_req_ack,
   input wire logic [11:0] ch_page_end,
   input wire logic [14:0] ch_addr [12],
   input wire logic [11:0] ch_rvalid,
   input wire logic [15:0] ch_rdata [12],
   input wire logic [11:0] ch_rperr,
   input wire logic [11:0] ch_rready
);
   // ------
   // Clocking
   // ------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Channels 0 and 1 both asking for one module at the same edge
   sequence s_clash;
      (ch_req_valid[1:0] == 2'h3) && (ch_req_ack[1:0] == 2'h0) && (ch_load[1:0] == 2'h0)
         && (ch_addr[0][2:0] == ch_addr[1][2:0]);
   endsequence
   // Receiver of channel 5 holding off a waiting word
   sequence s_stall;
      ch_rvalid[5] && !ch_rready[5];
   endsequence

   // ------
   // Checks
   // ------
   a_ack_one_cycle: assert property ((ch_req_ack & $past(ch_req_ack)) == 12'h000)
      else $error("ack stood longer than one cycle");
   a_ack_needs_req: assert property ((ch_req_ack & ~$past(ch_req_valid)) == 12'h000)
      else $error("ack without a request");
   a_page_end_ack: assert property ((ch_page_end & ~ch_req_ack) == 12'h000)
      else $error("page end outside an ack");
   a_addr_step: assert property (ch_req_ack[0] |-> ch_addr[0] == $past(ch_addr[0]) + 15'h0001)
      else $error("channel address did not step by one");
   a_page_end_addr: assert property (ch_req_ack[0] |-> ch_page_end[0] == ($past(ch_addr[0]) == 15'h07FF ||
      $past(ch_addr[0][10:0]) == 11'h7FF))
      else $error("page end does not match the last word of a page");
   a_load_addr: assert property (ch_load[0] |=> ch_addr[0] == $past(ch_load_addr[0]))
      else $error("loaded address not taken");
   a_load_blocks: assert property (ch_load[0] |=> !ch_req_ack[0])
      else $error("request taken while loading");
   a_prio_low_first: assert property (s_clash |=> !ch_req_ack[1])
      else $error("lower priority channel won the module");
   a_rdata_held: assert property (s_stall |=> ch_rvalid[5] && $stable(ch_rdata[5]) && $stable(ch_rperr[5]))
      else $error("read word changed while stalled");

   // Main scenario: the loser of a clash is served one module cycle later
   c_clash: cover property (s_clash ##CYCLE_CLKS 1'b1 ##1 ch_req_ack[1]);
endmodule // ibf_top_asserts

bind ibf_top ibf_top_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.clk, .reset_n, .ch_load, .ch_load_addr,
   .ch_req_valid, .ch_req_ack, .ch_page_end, .ch_addr, .ch_rvalid, .ch_rdata, .ch_rperr, .ch_rready);

/* ibf_chan_model.sv */
// Behavioural I/O interface logic on one memory access channel.
// Assumes the bench calls burst just after a rising edge and sets hold to stall reads.
`timescale 1ns/1ns
module ibf_chan_model (
   input wire logic clk,
   output logic valid,
   output logic write,
   output logic [15:0] wdata,
   input wire logic ack,
   input wire logic pe,
   input wire logic rvalid,
   input wire logic [15:0] rdata,
   input wire logic rperr,
   output logic rready
);
   time acks [$];
   logic [16:0] got [$];
   int pe_cnt = 0;
   bit hold = 1'b0;

   // Idle at time zero
   initial begin
      valid = 1'b0;
      write = 1'b0;
      wdata = 16'h0000;
      rready = 1'b1;
   end

   // Receiver: one word per edge with both flags, stalls while hold is set
   always @(posedge clk) begin
      if (rvalid === 1'b1 && rready)
         got.push_back({rperr, rdata});
      rready <= !hold;
   end

   // Requester: each word is held until ack is sampled high, then the next follows
   task automatic burst(input int n, input logic wr, input logic [15:0] d0);
      acks.delete();
      pe_cnt = 0;
      for (int i = 0; i < n; i++) begin
         valid <= 1'b1;
         write <= wr;
         wdata <= d0 + 16'(i);
         @(posedge clk);
         while (ack !== 1'b1)
            @(posedge clk);
         acks.push_back($time);
         if (pe === 1'b1)
            pe_cnt++;
      end
      valid <= 1'b0;
      // Released data line shows the inverse, not the last word
      wdata <= ~(d0 + 16'(n - 1));
   endtask
endmodule // ibf_chan_model

/* tb.sv */
// Self-checking bench for ibf_top with one partner model per channel.
// Assumes the checker binds itself to ibf_top; the module cycle is shortened.
`timescale 1ns/1ns
module tb;
   localparam int CYC = 16; // Eight banks at two clocks each exactly cover one cycle
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [11:0] ch_load = 12'h000;
   logic [14:0] ch_load_addr [12];
   wire [11:0] ch_req_valid;
   wire [11:0] ch_req_write;
   wire [15:0] ch_req_wdata [12];
   wire [11:0] ch_rready;
   logic [11:0] ch_req_ack;
   logic [11:0] ch_page_end;
   logic [14:0] ch_addr [12];
   logic [11:0] ch_rvalid;
   logic [15:0] ch_rdata [12];
   logic [11:0] ch_rperr;
   logic parity_alarm;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   int alarm_seen = 0;

   // 25 MHz clock
   always #20 clk = ~clk;

   ibf_top #(.CYCLE_CLKS(CYC)) u_dut (.clk, .reset_n, .ch_load, .ch_load_addr, .ch_req_valid, .ch_req_write,
      .ch_req_wdata, .ch_req_ack, .ch_page_end, .ch_addr, .ch_rvalid, .ch_rdata, .ch_rperr, .ch_rready,
      .parity_alarm);

   // One requester and receiver per channel
   for (genvar g = 0; g < 12; g++) begin : g_ch
      ibf_chan_model u_m (.clk, .valid(ch_req_valid[g]), .write(ch_req_write[g]), .wdata(ch_req_wdata[g]),
         .ack(ch_req_ack[g]), .pe(ch_page_end[g]), .rvalid(ch_rvalid[g]), .rdata(ch_rdata[g]),
         .rperr(ch_rperr[g]), .rready(ch_rready[g]));
   end

   // ------
   // Helpers
   // ------
   task automatic chk(input bit ok, input string m);
      checked++;
      if (!ok) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   // Supervisor load of a start address, seen on the next edge
   task automatic load(input int c, input logic [14:0] a);
      ch_load[c] <= 1'b1;
      ch_load_addr[c] <= a;
      @(posedge clk);
      ch_load[c] <= 1'b0;
      @(posedge clk);
      chk(ch_addr[c] === a, "start address not loaded");
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------
   // Scenarios
   // ------
   task automatic t_reset();
      chk(ch_req_ack === 12'h000 && ch_rvalid === 12'h000 && ch_addr[0] === 15'h0000, "reset state");
      $display("reset test done");
   endtask

   // Sequential writes across the page end and the top of memory, read back stalled
   task automatic t_stream();
      load(0, 15'h7FF8);
      g_ch[0].u_m.burst(16, 1'b1, 16'h5A00);
      chk(g_ch[0].u_m.acks[15] - g_ch[0].u_m.acks[0] == 30 * 40, "sequential spacing");
      chk(g_ch[0].u_m.pe_cnt == 1, "page end count");
      chk(ch_addr[0] === 15'h0008, "address wrap");
      load(5, 15'h7FF8);
      g_ch[5].u_m.hold = 1'b1;
      fork
         g_ch[5].u_m.burst(16, 1'b0, 16'h0000);
         begin
            repeat (40) @(posedge clk);
            g_ch[5].u_m.hold = 1'b0;
         end
      join
      for (int k = 0; k < 100 && g_ch[5].u_m.got.size() < 16; k++)
         @(posedge clk);
      for (int i = 0; i < 16; i++)
         chk(g_ch[5].u_m.got[i] === {1'b0, 16'h5A00 + 16'(i)}, "stream read word");
      $display("stream test done");
   endtask

   // Four channels at once, three of them on module 0
   task automatic t_clash();
      load(0, 15'h0300);
      load(1, 15'h0308);
      load(2, 15'h0301);
      load(11, 15'h0310);
      fork
         g_ch[0].u_m.burst(1, 1'b1, 16'h1111);
         g_ch[1].u_m.burst(1, 1'b1, 16'h2222);
         g_ch[2].u_m.burst(1, 1'b1, 16'h3333);
         g_ch[11].u_m.burst(1, 1'b1, 16'h4444);
      join
      chk(g_ch[2].u_m.acks[0] == g_ch[0].u_m.acks[0], "other module delayed");
      chk(g_ch[1].u_m.acks[0] - g_ch[0].u_m.acks[0] == CYC * 40, "second in module");
      chk(g_ch[11].u_m.acks[0] - g_ch[0].u_m.acks[0] == 2 * CYC * 40, "lowest served last");
      load(3, 15'h0300);
      g_ch[3].u_m.burst(2, 1'b0, 16'h0000);
      for (int k = 0; k < 100 && g_ch[3].u_m.got.size() < 2; k++)
         @(posedge clk);
      chk(g_ch[3].u_m.got[0] === {1'b0, 16'h1111}, "module 0 word");
      chk(g_ch[3].u_m.got[1] === {1'b0, 16'h3333}, "module 1 word");
      chk(alarm_seen == 0, "parity alarm raised");
      $display("clash test done");
   endtask

   // Cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      // Only written words are read back, so the alarm must stay low
      if (reset_n && parity_alarm !== 1'b0)
         alarm_seen <= alarm_seen + 1;
      if (cycles == 3000) begin
         error_cnt++;
         $display("[FAIL] %0t cycle limit reached", $time);
         end_of_test();
      end
   end

   // Main sequence
   initial begin
      foreach (ch_load_addr[i])
         ch_load_addr[i] = 15'h0000;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_stream();
      t_clash();
      end_of_test();
   end
endmodule // tb
